// File: fbs_pkg.sv
// Package for the fault, break and snoop signalling block.
// Assumes both ends share one 50 MHz clock and a synchronous reset.
package fbs_pkg;

    // ****************************************************************
    // Encodings and timing
    // ****************************************************************
    // The _n pins are active low: low means asserted
    localparam logic PIN_ON  = 1'b0;
    localparam logic PIN_OFF = 1'b1;

    // Snoop result codes carried on the two snoop lines
    typedef enum logic [1:0] {
        SNP_CLEAN = 2'b00,
        SNP_HIT   = 2'b01,
        SNP_MOD   = 2'b10,
        SNP_STALL = 2'b11
    } fbs_snoop_t;

    // Device fault / wake output states
    typedef enum logic [1:0] {
        FW_IDLE  = 2'b00,
        FW_FPERR = 2'b01,
        FW_BREAK = 2'b10
    } fbs_fw_state_t;

    // Cycles the power_off_cycle-type transaction marker is held
    localparam int unsigned SHUT_PULSE_CYC = 1;
    // Cycles after a snoop request before the device answers
    localparam int unsigned SNOOP_WAIT_CYC = 2;
    localparam logic [3:0]  SNOOP_WAIT_Q   = 4'h2;

endpackage : fbs_pkg

// File: fbs_if.sv
// Interface joining the device end and the core-logic end.
// Assumes the testbench resolves the shared snoop wires from the enables.
`timescale 1ns/10ps
interface fbs_if (
    input wire logic ref_clk
);
    // Device driven; the _n pins active low, power_off_cycle active high
    logic fault_or_wake_out_n;
    logic internal_fault_out_n;
    logic power_off_cycle;
    // Core logic driven; the _n pins active low, snoop_req active high
    logic clock_stop_request_n;
    logic bus_reinit_in_n;
    logic soft_init_in_n;
    logic probe_request_in_n;
    logic snoop_req;
    // Open-drain snoop lines, each party with its own drive
    logic snoop_shared_flag_n_o_dev;
    logic snoop_shared_flag_oe_dev;
    logic snoop_modified_flag_n_o_dev;
    logic snoop_modified_flag_oe_dev;
    logic snoop_shared_flag_n_o_sys;
    logic snoop_shared_flag_oe_sys;
    logic snoop_modified_flag_n_o_sys;
    logic snoop_modified_flag_oe_sys;
    logic snoop_shared_flag_n_i;
    logic snoop_modified_flag_n_i;

    modport dev (
        output fault_or_wake_out_n, internal_fault_out_n, power_off_cycle,
        output snoop_shared_flag_n_o_dev, snoop_shared_flag_oe_dev,
        output snoop_modified_flag_n_o_dev, snoop_modified_flag_oe_dev,
        input  clock_stop_request_n, bus_reinit_in_n, soft_init_in_n,
        input  probe_request_in_n, snoop_req,
        input  snoop_shared_flag_n_i, snoop_modified_flag_n_i
    );
    modport sys (
        input  fault_or_wake_out_n, internal_fault_out_n, power_off_cycle,
        output snoop_shared_flag_n_o_sys, snoop_shared_flag_oe_sys,
        output snoop_modified_flag_n_o_sys, snoop_modified_flag_oe_sys,
        output clock_stop_request_n, bus_reinit_in_n, soft_init_in_n,
        output probe_request_in_n, snoop_req,
        input  snoop_shared_flag_n_i, snoop_modified_flag_n_i
    );
endinterface : fbs_if

// File: fbs_dev.sv
// Device end: fault/wake output, internal fault, snoop result drive.
// Assumes core logic on ref_clk drives the request inputs; the fault
// and probe inputs are asynchronous and are synchronised here.
`timescale 1ns/10ps
module fbs_dev
    import fbs_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // Core side events (asynchronous, active high)
    input  wire logic fp_error_raw,
    input  wire logic fp_error_mask,
    input  wire logic break_event_raw,
    input  wire logic internal_error_raw,
    // Core side snoop result for the current request
    input  wire logic snoop_hit,
    input  wire logic snoop_modified,
    input  wire logic snoop_busy,
    // Link
    fbs_if.dev        bus
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [3:0] async_in;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    assign async_in = {fp_error_raw & ~fp_error_mask, break_event_raw,
                       internal_error_raw, ~bus.probe_request_in_n};
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
        end
    end

    logic fp_err_s;
    logic brk_s;
    logic internal_fault_out_s;
    logic probe_s;
    assign fp_err_s = sync2_q[3];
    assign brk_s    = sync2_q[2];
    assign internal_fault_out_s   = sync2_q[1];
    assign probe_s  = sync2_q[0];

    logic stop_on;
    logic init_on;
    assign stop_on = (bus.clock_stop_request_n == PIN_ON);
    assign init_on = (bus.bus_reinit_in_n == PIN_ON) ||
                     (bus.soft_init_in_n == PIN_ON);

    // ****************************************************************
    // Fault / wake output
    // ****************************************************************
    fbs_fw_state_t fw_q;
    fbs_fw_state_t fw_d;
    always_comb begin
        fw_d = fw_q;
        unique case (fw_q)
            FW_IDLE: begin
                if (stop_on && (brk_s || probe_s)) begin
                    fw_d = FW_BREAK;
                end else if (!stop_on && fp_err_s) begin
                    fw_d = FW_FPERR;
                end
            end
            FW_FPERR: begin
                if (stop_on && (brk_s || probe_s)) begin
                    fw_d = FW_BREAK;
                end else if (stop_on || !fp_err_s) begin
                    fw_d = FW_IDLE;
                end
            end
            FW_BREAK: begin
                // Held until the stop request goes away
                if (!stop_on) begin
                    fw_d = FW_IDLE;
                end
            end
            default: fw_d = FW_IDLE;
        endcase
    end

    logic fw_pin_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fw_q     <= FW_IDLE;
            fw_pin_q <= PIN_OFF;
        end else begin
            fw_q     <= fw_d;
            fw_pin_q <= (fw_d == FW_IDLE) ? PIN_OFF : PIN_ON;
        end
    end
    assign bus.fault_or_wake_out_n = fw_pin_q;

    // ****************************************************************
    // Internal fault and power_off_cycle marker
    // ****************************************************************
    logic internal_fault_out_q;
    logic internal_fault_out_d;
    logic shut_q;
    logic shut_d;
    always_comb begin
        internal_fault_out_d = internal_fault_out_q;
        shut_d = 1'b0;
        if (init_on) begin
            internal_fault_out_d = 1'b0;
        end else if (internal_fault_out_s && !internal_fault_out_q) begin
            internal_fault_out_d = 1'b1;
            shut_d = 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            internal_fault_out_q <= 1'b0;
            shut_q <= 1'b0;
        end else begin
            internal_fault_out_q <= internal_fault_out_d;
            shut_q <= shut_d;
        end
    end
    assign bus.internal_fault_out_n = internal_fault_out_q ? PIN_ON : PIN_OFF;
    assign bus.power_off_cycle      = shut_q;

    // ****************************************************************
    // Snoop result drive
    // ****************************************************************
    // Answer SNOOP_WAIT_CYC after the request; a busy core repeats the
    // stall code each window, which extends the stall.
    logic [3:0] swait_q;
    logic [3:0] swait_d;
    logic [1:0] sres_q;
    logic [1:0] sres_d;
    logic       sdrv_q;
    logic       sdrv_d;
    always_comb begin
        swait_d = swait_q;
        sres_d  = sres_q;
        sdrv_d  = 1'b0;
        if (bus.snoop_req && swait_q == 4'h0) begin
            swait_d = SNOOP_WAIT_Q;
        end else if (swait_q != 4'h0) begin
            swait_d = swait_q - 4'h1;
            if (swait_q == 4'h1) begin
                sdrv_d = 1'b1;
                if (snoop_busy) begin
                    sres_d  = SNP_STALL;
                    // One extra count keeps two quiet cycles per repeat
                    swait_d = SNOOP_WAIT_Q + 4'h1;
                end else begin
                    sres_d = {snoop_modified, snoop_hit};
                end
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            swait_q <= 4'h0;
            sres_q  <= SNP_CLEAN;
            sdrv_q  <= 1'b0;
        end else begin
            swait_q <= swait_d;
            sres_q  <= sres_d;
            sdrv_q  <= sdrv_d;
        end
    end
    // Open drain: only ever pull low, enable only while asserting
    assign bus.snoop_shared_flag_n_o_dev   = PIN_ON;
    assign bus.snoop_modified_flag_n_o_dev = PIN_ON;
    assign bus.snoop_shared_flag_oe_dev    = sdrv_q & sres_q[0];
    assign bus.snoop_modified_flag_oe_dev  = sdrv_q & sres_q[1];

endmodule : fbs_dev

// File: fbs_sys.sv
// Core-logic end: stop request, inits, probe, snoop observation.
// Assumes the device drives its outputs from flip-flops on ref_clk.
`timescale 1ns/10ps
module fbs_sys
    import fbs_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // User controls (active high)
    input  wire logic stop_clock,
    input  wire logic reinit,
    input  wire logic soft_init,
    input  wire logic probe,
    input  wire logic snoop_start,
    input  wire logic snoop_hit,
    input  wire logic snoop_modified,
    input  wire logic snoop_busy,
    // Observations
    output logic      fp_error_seen,
    output logic      break_seen,
    output logic      internal_fault_out_seen,
    output logic      nmi_pulse,
    output logic [1:0] snoop_result,
    output logic      snoop_stalled,
    // Link
    fbs_if.sys        bus
);

    // ****************************************************************
    // Request drive
    // ****************************************************************
    logic stop_q;
    logic stop_d;
    logic stop_age_q;
    logic [3:0] ctl_q;
    always_comb begin
        stop_d = stop_clock;
        // Release only once the device has seen the stop for a cycle;
        // a low pin in the first stop cycle is still an FP error.
        if (stop_q && stop_age_q && bus.fault_or_wake_out_n == PIN_ON) begin
            stop_d = 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stop_q     <= 1'b0;
            stop_age_q <= 1'b0;
            ctl_q      <= 4'h0;
        end else begin
            stop_q     <= stop_d;
            stop_age_q <= stop_q;
            ctl_q  <= {reinit, soft_init, probe, snoop_start};
        end
    end
    assign bus.clock_stop_request_n = stop_q ? PIN_ON : PIN_OFF;
    assign bus.bus_reinit_in_n      = ctl_q[3] ? PIN_ON : PIN_OFF;
    assign bus.soft_init_in_n       = ctl_q[2] ? PIN_ON : PIN_OFF;
    assign bus.probe_request_in_n   = ctl_q[1] ? PIN_ON : PIN_OFF;
    assign bus.snoop_req            = ctl_q[0];

    // Own snoop drive, registered every cycle from the inputs, stall while busy
    logic [1:0] own_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            own_q <= 2'b00;
        end else begin
            own_q <= snoop_busy ? SNP_STALL :
                     {snoop_modified, snoop_hit};
        end
    end
    assign bus.snoop_shared_flag_n_o_sys   = PIN_ON;
    assign bus.snoop_modified_flag_n_o_sys = PIN_ON;
    assign bus.snoop_shared_flag_oe_sys    = own_q[0];
    assign bus.snoop_modified_flag_oe_sys  = own_q[1];

    // ****************************************************************
    // Observation
    // ****************************************************************
    logic internal_fault_out_prev_q;
    logic [1:0] res_d;
    assign res_d = {bus.snoop_modified_flag_n_i == PIN_ON,
                    bus.snoop_shared_flag_n_i == PIN_ON};
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fp_error_seen <= 1'b0;
            break_seen    <= 1'b0;
            internal_fault_out_seen     <= 1'b0;
            internal_fault_out_prev_q   <= 1'b0;
            nmi_pulse     <= 1'b0;
            snoop_result  <= SNP_CLEAN;
            snoop_stalled <= 1'b0;
        end else begin
            fp_error_seen <= !stop_q && bus.fault_or_wake_out_n == PIN_ON;
            break_seen    <= stop_q && bus.fault_or_wake_out_n == PIN_ON;
            internal_fault_out_seen     <= bus.internal_fault_out_n == PIN_ON;
            internal_fault_out_prev_q   <= internal_fault_out_seen;
            // Power_off_cycle converted to an external error pulse
            nmi_pulse     <= bus.power_off_cycle;
            snoop_result  <= res_d;
            snoop_stalled <= (res_d == SNP_STALL);
        end
    end

endmodule : fbs_sys

// File: fbs_assertions.sv
// Checker for the fault, break and snoop link between both ends.
// Assumes it sits beside the interface, fed with its signals.
`timescale 1ns/10ps
module fbs_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Link signals
    input wire logic fault_or_wake_out_n,
    input wire logic internal_fault_out_n,
    input wire logic power_off_cycle,
    input wire logic clock_stop_request_n,
    input wire logic bus_reinit_in_n,
    input wire logic soft_init_in_n,
    input wire logic probe_request_in_n,
    input wire logic snoop_shared_flag_oe_dev,
    input wire logic snoop_modified_flag_oe_dev
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // ****************************************************************
    // Properties
    // ****************************************************************
    sequence brk_s;
        !clock_stop_request_n [*2] ##0 !fault_or_wake_out_n;
    endsequence
    sequence stall_s;
        snoop_shared_flag_oe_dev && snoop_modified_flag_oe_dev;
    endsequence
    sequence quiet_s;
        !snoop_shared_flag_oe_dev && !snoop_modified_flag_oe_dev;
    endsequence
    a_internal_fault_out_hold_fault: assert property (
        !internal_fault_out_n && bus_reinit_in_n && soft_init_in_n
        |=> !internal_fault_out_n) else $error("fault output dropped");
    a_internal_fault_out_init_clear: assert property (
        !bus_reinit_in_n || !soft_init_in_n |=> internal_fault_out_n)
        else $error("fault output not cleared by init");
    a_shut_with_internal_fault_out: assert property (
        power_off_cycle |-> $fell(internal_fault_out_n))
        else $error("power_off_cycle marker without fault edge");
    a_shut_one_pulse: assert property (
        power_off_cycle |=> !power_off_cycle)
        else $error("power_off_cycle marker too long");
    a_break_hold_stop: assert property (
        brk_s |=> clock_stop_request_n || !fault_or_wake_out_n)
        else $error("break indication dropped early");
    a_break_release: assert property (
        !clock_stop_request_n && $fell(fault_or_wake_out_n)
        |-> ##[1:3] clock_stop_request_n)
        else $error("stop request not released");
    a_probe_break: assert property (
        (!probe_request_in_n && !clock_stop_request_n) [*4]
        |-> !fault_or_wake_out_n) else $error("probe gave no break");
    a_snoop_one_cycle: assert property (
        snoop_shared_flag_oe_dev || snoop_modified_flag_oe_dev
        |=> quiet_s)
        else $error("snoop drive longer than one cycle");
    a_stall_gap: assert property (
        stall_s |=> quiet_s [*2]) else $error("stall repeated too soon");
endmodule : fbs_assertions

// File: fbs_test.sv
// Testbench joining the device end and core-logic end.
// Assumes the design files and package are compiled before it.
`timescale 1ns/10ps
module fbs_test;
    import fbs_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic fe, fm, be, ie, dh, dm, db;
    logic sc, ri, si, pr, ss, sh, sm, sb;
    logic fs, bs, is, np, st;
    logic [1:0] sr;
    int error_cnt = 0;
    int cmp_count = 0;
    fbs_if bus_if (.ref_clk(ref_clk));
    // Open-drain snoop lines: low while either end pulls
    assign bus_if.snoop_shared_flag_n_i = ~(bus_if.snoop_shared_flag_oe_dev
        | bus_if.snoop_shared_flag_oe_sys);
    assign bus_if.snoop_modified_flag_n_i =
        ~(bus_if.snoop_modified_flag_oe_dev
        | bus_if.snoop_modified_flag_oe_sys);
    fbs_dev fbs_dev_i (.ref_clk(ref_clk), .srst(srst), .fp_error_raw(fe),
        .fp_error_mask(fm), .break_event_raw(be), .internal_error_raw(ie),
        .snoop_hit(dh), .snoop_modified(dm), .snoop_busy(db), .bus(bus_if));
    fbs_sys fbs_sys_i (.ref_clk(ref_clk), .srst(srst), .stop_clock(sc),
        .reinit(ri), .soft_init(si), .probe(pr), .snoop_start(ss),
        .snoop_hit(sh), .snoop_modified(sm), .snoop_busy(sb),
        .fp_error_seen(fs), .break_seen(bs), .internal_fault_out_seen(is),
        .nmi_pulse(np), .snoop_result(sr), .snoop_stalled(st), .bus(bus_if));
    fbs_assertions fbs_assertions_i (.ref_clk(ref_clk), .srst(srst),
        .fault_or_wake_out_n(bus_if.fault_or_wake_out_n),
        .internal_fault_out_n(bus_if.internal_fault_out_n),
        .power_off_cycle(bus_if.power_off_cycle),
        .clock_stop_request_n(bus_if.clock_stop_request_n),
        .bus_reinit_in_n(bus_if.bus_reinit_in_n),
        .soft_init_in_n(bus_if.soft_init_in_n),
        .probe_request_in_n(bus_if.probe_request_in_n),
        .snoop_shared_flag_oe_dev(bus_if.snoop_shared_flag_oe_dev),
        .snoop_modified_flag_oe_dev(bus_if.snoop_modified_flag_oe_dev));
    always #10 ref_clk = ~ref_clk;
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic tick(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [1:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic sig(input int k);
        case (k)
            0: return bus_if.fault_or_wake_out_n;
            1: return bus_if.internal_fault_out_n;
            2: return bus_if.clock_stop_request_n;
            3: return bs;
            default: return bus_if.snoop_shared_flag_oe_dev
                | bus_if.snoop_modified_flag_oe_dev;
        endcase
    endfunction : sig
    // Bounded wait, so a stuck output is reported rather than hung on
    task automatic wait_val(input int k, input logic v, input string nm);
        for (int i = 0; i < 12 && sig(k) !== v; i++) tick();
        chk(nm, {1'b0, sig(k)}, {1'b0, v});
    endtask : wait_val
    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        wrap_up();
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {fe, fm, be, ie, dh, dm, db, sc, ri, si, pr, ss, sh, sm, sb} = '0;
        tick(5);
        srst = 1'b0;
        tick();
        chk("idle pins", {bus_if.fault_or_wake_out_n,
            bus_if.internal_fault_out_n}, 2'b11);
        $display("test reset done");
        fe = 1'b1;
        tick(3);
        chk("fp error", bus_if.fault_or_wake_out_n, PIN_ON);
        tick();
        chk("fp seen", fs, 1'b1);
        fm = 1'b1;
        wait_val(0, PIN_OFF, "fp masked");
        fm = 1'b0;
        sc = 1'b1;
        tick(6);
        chk("fp under stop", bus_if.fault_or_wake_out_n, PIN_OFF);
        fe = 1'b0;
        be = 1'b1;
        tick(3);
        chk("break", bus_if.fault_or_wake_out_n, PIN_ON);
        be = 1'b0;
        sc = 1'b0;
        wait_val(3, 1'b1, "break seen");
        wait_val(2, PIN_OFF, "stop released");
        wait_val(0, PIN_OFF, "break cleared");
        sc = 1'b1;
        pr = 1'b1;
        wait_val(0, PIN_ON, "probe break");
        {sc, pr} = '0;
        wait_val(0, PIN_OFF, "probe cleared");
        $display("test fault wake done");
        for (int i = 0; i < 2; i++) begin
            ie = 1'b1;
            tick(3);
            chk("internal_fault_out", bus_if.internal_fault_out_n, PIN_ON);
            chk("shut", bus_if.power_off_cycle, 1'b1);
            ie = 1'b0;
            tick();
            chk("nmi", np, 1'b1);
            chk("internal_fault_out seen", is, 1'b1);
            tick(10);
            chk("internal_fault_out held", bus_if.internal_fault_out_n, PIN_ON);
            {ri, si} = (i == 0) ? 2'b10 : 2'b01;
            tick();
            {ri, si} = '0;
            wait_val(1, PIN_OFF, "internal_fault_out cleared");
        end
        $display("test internal fault done");
        for (int i = 1; i < 4; i++) begin
            {dm, dh} = i[1:0];
            db = (i == 3);
            ss = 1'b1;
            tick();
            ss = 1'b0;
            wait_val(4, 1'b1, "snoop drive");
            tick();
            chk("snoop result", sr, i[1:0]);
            if (i == 3) chk("stalled", st, 1'b1);
            db = 1'b0;
            tick(8);
        end
        sb = 1'b1;
        tick();
        sb = 1'b0;
        tick();
        chk("sys stall", st, 1'b1);
        $display("test snoop done");
        wrap_up();
    end
endmodule : fbs_test
